// ---- hw/pcid_top.sv ----
// top: input decoder, six-digit main counter and apb registers
`timescale 1ns/100ps
// Operation
// - slow mode filters inputs, limits pulse rate
// - fast mode accepts pulses without filtering
// - codes 0,1: secondary holds, primary sub/add
// - codes 4-7: secondary sub/add, primary sub/add
// - codes 8,9: secondary level selects direction
// - codes 12,13: quadrature, always fast
// - codes 14,15: double quadrature, always fast
// - rising edges, primary falls in fast
// - npn or contact sensors invert input levels
// - up: start at offset, presets fire
// - down: start at preset two, fire at offset
// - totalizer always counts upward
// - decrement at zero loads max, toggles wrap
// - increment past max after wrap clears flag
// - increment at max loads zero, toggles wrap
// - wrap flag suppresses preset comparisons
module pcid_top #(
  parameter int FILT_CYC = pcid_pkg::SLOW_FILT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        primary_pulse_in,
  input  wire logic        secondary_pulse_in,
  output logic      [19:0] count_out,
  output logic      [31:0] total_out,
  output logic             wrap_flag,
  output logic             preset1_hit,
  output logic             preset2_hit,
  output logic             irq
);
  typedef enum logic [1:0] {
    PCID_IDLE   = 2'b01,
    PCID_ACCESS = 2'b10
  } pcid_bus_t;

  // registers
  logic [5:0]  ctrl_q;
  logic [19:0] offset_q;
  logic [19:0] preset1_q;
  logic [19:0] second_preset;
  logic [19:0] cnt_q;
  logic [31:0] tot_q;
  logic        wrap_q;
  logic [2:0]  ist_q;
  logic [2:0]  ien_q;
  logic        p1_q;
  logic        p2_q;
  logic [31:0] prdata_q;
  pcid_bus_t   bus_q;

  logic [3:0] code;
  logic       speed_select;
  logic       sensor_type_select;
  assign code               = ctrl_q[pcid_pkg::CODE_LSB +: 4];
  assign speed_select       = ctrl_q[pcid_pkg::SPEED_BIT];
  assign sensor_type_select = ctrl_q[pcid_pkg::SENS_BIT];

  // apb decode: single-cycle access phase, zero wait states
  logic wr_en;
  logic rd_en;
  logic load_req;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign load_req = wr_en && paddr == pcid_pkg::LOAD_OFS;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= pcid_pkg::LOAD_OFS) && (a[1:0] == 2'b00);
  endfunction
  assign pslverr = psel & penable & ~mapped(paddr);

  // bus phase tracker, mainly documents the setup/access split
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= PCID_IDLE;
    end else begin
      unique case (bus_q)
        PCID_IDLE:   bus_q <= (psel & ~penable) ? PCID_ACCESS : PCID_IDLE;
        PCID_ACCESS: bus_q <= PCID_IDLE;
        default:     bus_q <= PCID_IDLE;
      endcase
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q        <= 6'h01;
      offset_q      <= 20'h00000;
      preset1_q     <= 20'h00000;
      second_preset <= 20'h00000;
      ien_q         <= 3'h0;
    end else if (wr_en) begin
      unique case (paddr)
        pcid_pkg::CTRL_OFS:    ctrl_q        <= pwdata[5:0];
        pcid_pkg::OFFSET_OFS:  offset_q      <= pwdata[19:0];
        pcid_pkg::PRESET1_OFS: preset1_q     <= pwdata[19:0];
        pcid_pkg::PRESET2_OFS: second_preset <= pwdata[19:0];
        pcid_pkg::IRQ_EN_OFS:  ien_q         <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // read data registered in setup, valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_en) begin
      unique case (paddr)
        pcid_pkg::CTRL_OFS:    prdata_q <= {26'h0, ctrl_q};
        pcid_pkg::OFFSET_OFS:  prdata_q <= {12'h0, offset_q};
        pcid_pkg::PRESET1_OFS: prdata_q <= {12'h0, preset1_q};
        pcid_pkg::PRESET2_OFS: prdata_q <= {12'h0, second_preset};
        pcid_pkg::COUNT_OFS:   prdata_q <= {12'h0, cnt_q};
        pcid_pkg::STAT_OFS:    prdata_q <= {29'h0, p2_q, p1_q, wrap_q};
        pcid_pkg::IRQ_ST_OFS:  prdata_q <= {29'h0, ist_q};
        pcid_pkg::IRQ_EN_OFS:  prdata_q <= {29'h0, ien_q};
        default:               prdata_q <= 32'h00000000;
      endcase
    end
  end
  assign prdata = prdata_q;

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {s1_q[1:0], primary_pulse_in};
      s2_q <= {s2_q[1:0], secondary_pulse_in};
    end
  end

  // stable levels change only when stages two and three agree
  logic a_lvl_q;
  logic b_lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_lvl_q <= 1'b0;
      b_lvl_q <= 1'b0;
    end else begin
      if (s1_q[1] == s1_q[2]) a_lvl_q <= s1_q[2];
      if (s2_q[1] == s2_q[2]) b_lvl_q <= s2_q[2];
    end
  end

  logic a_raw;
  logic b_raw;
  assign a_raw = a_lvl_q ^ sensor_type_select;
  assign b_raw = b_lvl_q ^ sensor_type_select;

  logic is_quad;
  logic slow;
  assign is_quad = code[3] & code[2];
  assign slow    = ~speed_select & ~is_quad;

  // slow filter: level must hold FILT_CYC cycles
  logic [31:0] fa_cnt_q;
  logic [31:0] fb_cnt_q;
  logic        a_f_q;
  logic        b_f_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_cnt_q <= 32'h0;
      fb_cnt_q <= 32'h0;
      a_f_q    <= 1'b0;
      b_f_q    <= 1'b0;
    end else begin
      if (!slow || a_raw == a_f_q) begin
        fa_cnt_q <= 32'h0;
        if (!slow) a_f_q <= a_raw;
      end else if (fa_cnt_q >= 32'(FILT_CYC - 1)) begin
        a_f_q    <= a_raw;
        fa_cnt_q <= 32'h0;
      end else begin
        fa_cnt_q <= fa_cnt_q + 32'h1;
      end
      if (!slow || b_raw == b_f_q) begin
        fb_cnt_q <= 32'h0;
        if (!slow) b_f_q <= b_raw;
      end else if (fb_cnt_q >= 32'(FILT_CYC - 1)) begin
        b_f_q    <= b_raw;
        fb_cnt_q <= 32'h0;
      end else begin
        fb_cnt_q <= fb_cnt_q + 32'h1;
      end
    end
  end

  // edge detect on filtered levels
  logic a_d_q;
  logic b_d_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_d_q <= 1'b0;
      b_d_q <= 1'b0;
    end else begin
      a_d_q <= a_f_q;
      b_d_q <= b_f_q;
    end
  end
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  assign a_rise = a_f_q & ~a_d_q;
  assign a_fall = ~a_f_q & a_d_q;
  assign b_rise = b_f_q & ~b_d_q;
  assign b_fall = ~b_f_q & b_d_q;

  // primary uses falling edge only in fast mode
  logic a_ev;
  assign a_ev = speed_select ? a_fall : a_rise;

  // decode into one increment and one decrement request
  logic inc;
  logic dec;
  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    unique case (code)
      pcid_pkg::C_HOLD_DN: dec = a_ev & ~b_f_q;
      pcid_pkg::C_HOLD_UP: inc = a_ev & ~b_f_q;
      // both inputs count; simultaneous pulses cancel
      pcid_pkg::C_SS_DN,
      pcid_pkg::C_SA_UP,
      pcid_pkg::C_AS_DN,
      pcid_pkg::C_AA_UP: begin
        inc = (code[0] & a_ev) ^ (code[1] & b_rise);
        dec = (~code[0] & a_ev) ^ (~code[1] & b_rise);
        if (inc & dec) begin
          inc = 1'b0;
          dec = 1'b0;
        end
      end
      pcid_pkg::C_SEL_DN: begin
        inc = a_ev & b_f_q;
        dec = a_ev & ~b_f_q;
      end
      pcid_pkg::C_SEL_UP: begin
        inc = a_ev & ~b_f_q;
        dec = a_ev & b_f_q;
      end
      // quadrature: count on primary rise, b gives sense
      pcid_pkg::C_QD_DN,
      pcid_pkg::C_QD_UP: begin
        inc = a_rise & ~b_f_q;
        dec = a_rise & b_f_q;
      end
      pcid_pkg::C_Q2_DN,
      pcid_pkg::C_Q2_UP: begin
        inc = (a_rise & ~b_f_q) | (a_fall & b_f_q);
        dec = (a_rise & b_f_q) | (a_fall & ~b_f_q);
      end
      default: ;
    endcase
  end

  logic dir_up;
  assign dir_up = code[0];

  // main counter; load restarts from offset or second preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 20'h00000;
      wrap_q <= 1'b0;
    end else if (load_req) begin
      cnt_q  <= dir_up ? offset_q : second_preset;
      wrap_q <= 1'b0;
    end else if (inc) begin
      if (cnt_q == pcid_pkg::CNT_MAX) begin
        cnt_q  <= pcid_pkg::CNT_ZERO;
        wrap_q <= ~wrap_q;
      end else begin
        cnt_q <= cnt_q + 20'h1;
      end
    end else if (dec) begin
      if (cnt_q == pcid_pkg::CNT_ZERO) begin
        cnt_q  <= pcid_pkg::CNT_MAX;
        wrap_q <= ~wrap_q;
      end else begin
        cnt_q <= cnt_q - 20'h1;
      end
    end
  end

  // totalizer counts every accepted pulse upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tot_q <= 32'h0;
    end else if (inc | dec) begin
      tot_q <= tot_q + 32'h1;
    end
  end

  logic sp1_now;
  logic sp2_now;
  assign sp1_now = ~wrap_q & (cnt_q == preset1_q);
  assign sp2_now = ~wrap_q &
                   (dir_up ? cnt_q == second_preset : cnt_q == offset_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
    end else begin
      p1_q <= sp1_now;
      p2_q <= sp2_now;
    end
  end

  // sticky events; a set in the clear cycle wins
  logic [2:0] ev;
  logic [2:0] clr;
  logic       wrap_d_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wrap_d_q <= 1'b0;
    else          wrap_d_q <= wrap_q;
  end
  assign ev  = {sp2_now & ~p2_q, sp1_now & ~p1_q, wrap_q & ~wrap_d_q};
  assign clr = (wr_en && paddr == pcid_pkg::IRQ_CLR_OFS) ? pwdata[2:0]
                                                          : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ist_q <= 3'h0;
    else          ist_q <= (ist_q & ~clr) | ev;
  end

  assign irq         = |(ist_q & ien_q);
  assign count_out   = cnt_q;
  assign total_out   = tot_q;
  assign wrap_flag   = wrap_q;
  assign preset1_hit = p1_q;
  assign preset2_hit = p2_q;

  // zero plus decrement gives max next cycle
  AST_UNDERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (!load_req && dec && !inc && cnt_q == pcid_pkg::CNT_ZERO)
      |=> (cnt_q == pcid_pkg::CNT_MAX && wrap_q != $past(wrap_q)))
    else $error("underflow did not wrap");
  AST_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (!load_req && inc && cnt_q == pcid_pkg::CNT_MAX)
      |=> (cnt_q == pcid_pkg::CNT_ZERO && wrap_q != $past(wrap_q)))
    else $error("overflow did not wrap");
  AST_WRAP_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    $past(wrap_q) |-> !p1_q && !p2_q)
    else $error("preset hit while wrapped");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (code == pcid_pkg::C_HOLD_UP && b_f_q) |-> !inc && !dec)
    else $error("count during hold");
  AST_QUAD_FAST: assert property (@(posedge pclk) disable iff (!presetn)
    is_quad |=> a_f_q == $past(a_raw))
    else $error("quadrature filtered");
  // slow primary counts on rising edge
  AST_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (code == pcid_pkg::C_AA_UP && !speed_select && a_fall && !b_rise)
      |-> !inc)
    else $error("counted on wrong edge");
  // totalizer rises by one per pulse
  AST_TOTAL: assert property (@(posedge pclk) disable iff (!presetn)
    (inc || dec) |=> tot_q == $past(tot_q) + 32'h1)
    else $error("totalizer not up");
  AST_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    (code == pcid_pkg::C_SEL_UP && a_ev && b_f_q) |-> dec && !inc)
    else $error("select direction wrong");
  // access phase only ever follows its own setup cycle
  AST_APB_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> bus_q == PCID_ACCESS)
    else $error("access without setup");
endmodule

// ---- hw/pcid_pkg.sv ----
// package: constants for the pulse counter input decoder
package pcid_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] OFFSET_OFS  = 8'h04;
  localparam logic [7:0] PRESET1_OFS = 8'h08;
  localparam logic [7:0] PRESET2_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS    = 8'h14;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS  = 8'h1c;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h20;
  localparam logic [7:0] LOAD_OFS    = 8'h24;
  // control field positions
  localparam int CODE_LSB  = 0;
  localparam int SPEED_BIT = 4;
  localparam int SENS_BIT  = 5;
  // status / irq bit positions
  localparam int EV_WRAP  = 0;
  localparam int EV_SP1   = 1;
  localparam int EV_SP2   = 2;
  localparam int EV_NUM   = 3;
  // counter limits
  localparam logic [19:0] CNT_MAX  = 20'hf423f;
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  // slow mode filter time
  localparam int SLOW_FILT_US = 5000;
  localparam int CLK_MHZ      = 250;
  localparam int SLOW_FILT_CYC = SLOW_FILT_US * CLK_MHZ;
  // direction / function codes
  localparam logic [3:0] C_HOLD_DN = 4'h0;
  localparam logic [3:0] C_HOLD_UP = 4'h1;
  localparam logic [3:0] C_SS_DN   = 4'h4;
  localparam logic [3:0] C_SA_UP   = 4'h5;
  localparam logic [3:0] C_AS_DN   = 4'h6;
  localparam logic [3:0] C_AA_UP   = 4'h7;
  localparam logic [3:0] C_SEL_DN  = 4'h8;
  localparam logic [3:0] C_SEL_UP  = 4'h9;
  localparam logic [3:0] C_QD_DN   = 4'hc;
  localparam logic [3:0] C_QD_UP   = 4'hd;
  localparam logic [3:0] C_Q2_DN   = 4'he;
  localparam logic [3:0] C_Q2_UP   = 4'hf;
endpackage

// ---- tb/pcid_pulse_src.sv ----
// pulse source: sensor pins driven from logical levels
`timescale 1ns/100ps
module pcid_pulse_src (
  input  wire logic pclk,
  output logic      a_pin,
  output logic      b_pin
);
  logic a_lvl = 1'b0;
  logic b_lvl = 1'b0;
  logic inv   = 1'b0;
  // pins idle low from time zero, before the first edge
  initial begin
    a_pin = 1'b0;
    b_pin = 1'b0;
  end
  // npn and contact sensors sink current, so active reads low
  always @(posedge pclk) begin
    a_pin <= a_lvl ^ inv;
    b_pin <= b_lvl ^ inv;
  end
  // new levels land on the next rising edge, never mid-cycle
  task automatic drive(input logic a, input logic b, input logic i);
    a_lvl = a;
    b_lvl = b;
    inv = i;
  endtask
endmodule

// ---- tb/testbench.sv ----
// testbench: decode modes, wrap and irq over apb and pins
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, tot, tbase;
  logic        pready, pslverr, pa, pb, wrap, hit1, hit2, irq;
  logic        err, sens;
  logic [19:0] cnt, st;
  int          err_count, n_tests, seed, k;
  int          codes[8] = '{0, 1, 4, 5, 6, 7, 8, 9};

  pcid_top #(.FILT_CYC(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primary_pulse_in(pa),
    .secondary_pulse_in(pb), .count_out(cnt), .total_out(tot),
    .wrap_flag(wrap), .preset1_hit(hit1), .preset2_hit(hit2), .irq(irq)
  );
  pcid_pulse_src u_src (.pclk(pclk), .a_pin(pa), .b_pin(pb));

  // expected count change of the eight-step pulse pattern
  function automatic int dexp(int c);
    case (c)
      0: return -1;
      1: return 1;
      4: return -4;
      5: return 2;
      6: return -2;
      7: return 4;
      8: return 1;
      default: return -1;
    endcase
  endfunction
  // start value moved by d, counter width
  function automatic logic [31:0] ce(int d);
    return {12'h000, 20'(int'(st) + d)};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // hold levels long enough for sync and the slow filter
  task automatic lv(input logic a, input logic b);
    u_src.drive(a, b, sens);
    repeat (24) @(posedge pclk);
    #1;
  endtask
  task automatic setup(input int c, input int s, input logic [19:0] off,
                       input logic [19:0] p2);
    apb(1'b1, pcid_pkg::OFFSET_OFS, {12'h000, off});
    apb(1'b1, pcid_pkg::PRESET2_OFS, {12'h000, p2});
    apb(1'b1, pcid_pkg::CTRL_OFS, 32'(int'(sens) * 32 + s * 16 + c));
    lv(1'b0, 1'b0);
    apb(1'b1, pcid_pkg::LOAD_OFS, 32'h00000000);
    st = c[0] ? off : p2;
    tbase = tot;
    chk({12'h000, cnt}, ce(0));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // watchdog: fires after 50k cycles; the whole sequence needs well under that
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sens = 1'b0;
    seed = 93;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pcid_pkg::CTRL_OFS, 32'h00000000);
    chk(rd, 32'h00000001);
    // unmapped read is refused and returns zero
    apb(1'b0, 8'h28, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    // every plain code, both speeds, random sensor type and offset
    for (int s = 0; s < 2; s++) begin
      foreach (codes[i]) begin
        k = codes[i];
        sens = 1'($random(seed));
        setup(k, s, 20'h003e8 + 20'($random(seed) & 32'h0000ffff),
              20'h13880);
        lv(1'b1, 1'b0);
        chk({12'h000, cnt}, ce(s ? 0 : (k % 2 ? 1 : -1)));
        for (int j = 1; j < 8; j++) begin
          lv(8'h29 >> j & 1, 8'h7c >> j & 1);
        end
        chk({12'h000, cnt}, ce(dexp(k)));
        chk(tot - tbase, (k < 2) ? 1 : (k < 8 ? 4 : 3));
        // a five-cycle pulse passes only without the slow filter
        u_src.drive(1'b1, 1'b0, sens);
        repeat (5) @(posedge pclk);
        lv(1'b0, 1'b0);
        chk({12'h000, cnt}, ce(dexp(k) + (s ? (k % 2 ? 1 : -1) : 0)));
      end
    end
    // quadrature with slow selected: the short pulse still counts;
    // at double resolution its falling edge takes the count back
    sens = 1'b0;
    for (k = 12; k < 16; k++) begin
      setup(k, 0, 20'h00100, 20'h00200);
      u_src.drive(1'b1, 1'b0, sens);
      repeat (5) @(posedge pclk);
      lv(1'b0, 1'b0);
      chk({12'h000, cnt}, ce(k < 14 ? 1 : 0));
      lv(1'b0, 1'b1);
      lv(1'b1, 1'b1);
      chk({12'h000, cnt}, ce(k < 14 ? 0 : -1));
      lv(1'b0, 1'b1);
      chk({12'h000, cnt}, ce(0));
      lv(1'b0, 1'b0);
    end
    // wrap below zero, irq masking and clearing
    apb(1'b1, pcid_pkg::PRESET1_OFS, 32'h00000000);
    apb(1'b1, pcid_pkg::IRQ_EN_OFS, 32'h00000001);
    setup(8, 1, 20'h00000, 20'h00000);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
    chk({12'h000, cnt}, 32'h000f423f);
    chk({31'h0, wrap}, 32'h00000001);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b1, pcid_pkg::IRQ_EN_OFS, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    apb(1'b1, pcid_pkg::IRQ_EN_OFS, 32'h00000001);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b1, pcid_pkg::IRQ_CLR_OFS, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b0, 1'b1);
    chk({12'h000, cnt}, 32'h00000000);
    chk({31'h0, wrap}, 32'h00000000);
    chk({31'h0, hit1}, 32'h00000001);
    chk({31'h0, hit2}, 32'h00000001);
    apb(1'b0, pcid_pkg::COUNT_OFS, 32'h00000000);
    chk(rd, 32'h00000000);
    // wrap above max; preset match is ignored meanwhile
    setup(9, 1, 20'hf423f, 20'h00000);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
    chk({12'h000, cnt}, 32'h00000000);
    chk({31'h0, wrap}, 32'h00000001);
    chk({31'h0, hit1}, 32'h00000000);
    chk({31'h0, hit2}, 32'h00000000);
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b0, 1'b1);
    chk({12'h000, cnt}, 32'h000f423f);
    chk({31'h0, wrap}, 32'h00000000);
    report_and_stop();
  end
endmodule
